// *** rtl/gpsi_regs.svh ***
`ifndef GPSI_REGS_SVH
`define GPSI_REGS_SVH

// ----------------------------------------------------------------
// Pad configuration codes
// ----------------------------------------------------------------
`define GPSI_MODE_INPUT 2'h0
`define GPSI_MODE_OUTPUT 2'h1
`define GPSI_MODE_ALT 2'h2

// Pin-configuration parameters that turn on the indicator: 1,0,2
`define GPSI_IND_PAD 4'h1
`define GPSI_IND_DIR 2'h0
`define GPSI_IND_MODE 2'h2

// Converter-read parameters: 1,2
`define GPSI_ADC_CH 4'h1
`define GPSI_ADC_FMT 4'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GPSI_CLK_HZ 100000000
`define GPSI_ON_MS 1000
`define GPSI_OFF_MS 2000
`define GPSI_ADC_FULL_MV 1700
`define GPSI_ADC_MAX_CODE 255

`endif

// *** rtl/gpsi_pkg.sv ***
package gpsi_pkg;

    typedef enum logic [3:0] {
        GPSI_NET_OFF = 4'b0001,
        GPSI_NET_UNREG = 4'b0010,
        GPSI_NET_IDLE = 4'b0100,
        GPSI_NET_PSAVE = 4'b1000
    } gpsi_net_t;

    // Pin-configuration command: pad number (1-based), direction, mode
    typedef struct packed {
        logic [3:0] pad;
        logic [1:0] dir;
        logic [1:0] mode;
    } gpsi_pin_cmd_t;

    typedef struct packed {
        logic [3:0] ch;
        logic [3:0] fmt;
    } gpsi_adc_cmd_t;

endpackage : gpsi_pkg

// *** rtl/gpsi_blink.sv ***
`include "gpsi_regs.svh"

module gpsi_blink
import gpsi_pkg::*;
#(
    parameter int unsigned ON_CYC = 100000000,
    parameter int unsigned OFF_CYC = 200000000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic restart,
    output logic led_on
);
    localparam int unsigned PERIOD = ON_CYC + OFF_CYC;
    localparam int W = $clog2(PERIOD);

    logic [W-1:0] cnt_ff;

    // ------------------------------------------------------------
    // Phase counter: on phase first, then off phase
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset || restart) begin
            cnt_ff <= '0;
        end else if (cnt_ff == W'(PERIOD - 1)) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end

    assign led_on = (cnt_ff < W'(ON_CYC));
endmodule : gpsi_blink

// *** rtl/gpsi_gpio.sv ***
// Notes on behaviour
// - Input pad reads return the pad level at the read time.
// - Output pad takes written level and reads it back; no input role.
// - Alternate-function pad follows firmware function, not user writes.
// - Ten bidirectional pads with pull-down; undriven pad reads low.
// - Output pads drive push-pull, both levels actively.
// - Indicator pin is inverted: LED on means pin low.
// - Registered idle or dial-up blinks 1 s on, 2 s off.
// - Not registered or voice call: LED on; device off: LED off.
// - Idle with power saving updates only on paging wakeup events or a voice call.
// - Sample analogue input 0 to 1.7 V into an 8-bit result.
// - Converter-read command 1,2 reports result in millivolts.
`include "gpsi_regs.svh"

module gpsi_gpio
import gpsi_pkg::*;
#(
    parameter int NPAD = 10,
    parameter int unsigned ON_MS = `GPSI_ON_MS,
    parameter int unsigned OFF_MS = `GPSI_OFF_MS
) (
    input wire logic clk,
    input wire logic reset,
    // Pin-configuration command
    input wire logic cfg_valid,
    input wire gpsi_pin_cmd_t cfg_cmd,
    // Output level write, one bit per pad
    input wire logic wr_valid,
    input wire logic [NPAD-1:0] wr_mask,
    input wire logic [NPAD-1:0] wr_level,
    // Pad level read
    input wire logic rd_valid,
    output logic rd_done,
    output logic [NPAD-1:0] rd_level,
    output logic [NPAD-1:0] out_level,
    output logic [NPAD*2-1:0] pad_mode,
    // Firmware drive for alternate functions
    input wire logic [NPAD-1:0] alt_out,
    input wire logic [NPAD-1:0] alt_oe,
    // Network and call state
    input wire gpsi_net_t net_state,
    input wire logic voice_call,
    input wire logic dialup,
    input wire logic paging_wake,
    // Pads, split into four signals
    input wire logic [NPAD-1:0] pad_in,
    output logic [NPAD-1:0] pad_out,
    output logic [NPAD-1:0] pad_oe,
    output logic [NPAD-1:0] pad_pd_en,
    // Converter
    input wire logic adc_valid,
    input wire gpsi_adc_cmd_t adc_cmd,
    input wire logic [7:0] analog_input_one,
    output logic adc_done,
    output logic adc_err,
    output logic [10:0] adc_mv
);
    localparam int unsigned ON_CYC =
        (`GPSI_CLK_HZ / 1000) * ON_MS;
    localparam int unsigned OFF_CYC =
        (`GPSI_CLK_HZ / 1000) * OFF_MS;

    logic [NPAD*2-1:0] mode_ff;
    logic [NPAD-1:0] out_ff;
    logic [NPAD-1:0] rd_ff;
    logic rd_done_ff;
    logic ind_en_ff;
    logic ind_led_ff;
    gpsi_net_t net_ff;
    logic call_ff;
    logic dial_ff;
    logic [10:0] adc_mv_ff;
    logic adc_done_ff;
    logic adc_err_ff;
    logic blink_on;
    logic restart;
    logic nxt_led;
    logic [18:0] mv_prod;

    // ------------------------------------------------------------
    // Pad configuration
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_ff <= '0;
            ind_en_ff <= 1'b0;
        end else if (cfg_valid && cfg_cmd.pad != 4'h0 &&
                     cfg_cmd.pad <= 4'(NPAD)) begin
            mode_ff[(cfg_cmd.pad - 4'h1)*2 +: 2] <= cfg_cmd.mode;
            if (cfg_cmd.pad == `GPSI_IND_PAD) begin
                ind_en_ff <= (cfg_cmd.dir == `GPSI_IND_DIR) &&
                             (cfg_cmd.mode == `GPSI_IND_MODE);
            end
        end
    end

    // ------------------------------------------------------------
    // Output levels
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            out_ff <= '0;
        end else if (wr_valid) begin
            for (int i = 0; i < NPAD; i++) begin
                // Writes to pads not in output mode are dropped
                if (wr_mask[i] &&
                    mode_ff[i*2 +: 2] == `GPSI_MODE_OUTPUT) begin
                    out_ff[i] <= wr_level[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NPAD; i++) begin
            pad_pd_en[i] = 1'b1;
            unique case (mode_ff[i*2 +: 2])
                `GPSI_MODE_OUTPUT: begin
                    pad_out[i] = out_ff[i];
                    pad_oe[i] = 1'b1;
                end
                `GPSI_MODE_ALT: begin
                    if (i == 0 && ind_en_ff) begin
                        pad_out[i] = ~ind_led_ff;
                        pad_oe[i] = 1'b1;
                    end else begin
                        pad_out[i] = alt_out[i];
                        pad_oe[i] = alt_oe[i];
                    end
                end
                default: begin
                    pad_out[i] = 1'b0;
                    pad_oe[i] = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_ff <= '0;
            rd_done_ff <= 1'b0;
        end else begin
            rd_done_ff <= rd_valid;
            if (rd_valid) begin
                for (int i = 0; i < NPAD; i++) begin
                    // Output pads report the written level, not the pin
                    if (mode_ff[i*2 +: 2] == `GPSI_MODE_OUTPUT) begin
                        rd_ff[i] <= out_ff[i];
                    end else begin
                        rd_ff[i] <= pad_in[i];
                    end
                end
            end
        end
    end

    assign rd_done = rd_done_ff;
    assign rd_level = rd_ff;
    assign out_level = out_ff;
    assign pad_mode = mode_ff;

    // ------------------------------------------------------------
    // Status indicator
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            net_ff <= GPSI_NET_OFF;
            call_ff <= 1'b0;
            dial_ff <= 1'b0;
        end else begin
            net_ff <= net_state;
            call_ff <= voice_call;
            dial_ff <= dialup;
        end
    end

    assign restart = (net_ff != net_state) || (call_ff != voice_call) ||
                     (dial_ff != dialup);

    gpsi_blink #(
        .ON_CYC(ON_CYC),
        .OFF_CYC(OFF_CYC)
    ) u_blink (
        .clk(clk),
        .reset(reset),
        .restart(restart),
        .led_on(blink_on)
    );

    always_comb begin
        nxt_led = ind_led_ff;
        unique case (net_ff)
            GPSI_NET_OFF: nxt_led = 1'b0;
            GPSI_NET_UNREG: nxt_led = 1'b1;
            GPSI_NET_IDLE: begin
                // Voice call overrides blinking; dial-up blinks
                nxt_led = call_ff ? 1'b1 : blink_on;
            end
            GPSI_NET_PSAVE: begin
                // Clock may be gated here, so only paging wakes and voice calls count
                if (call_ff) begin
                    nxt_led = 1'b1;
                end else if (paging_wake) begin
                    nxt_led = ~ind_led_ff;
                end
            end
            default: nxt_led = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ind_led_ff <= 1'b0;
        end else begin
            ind_led_ff <= nxt_led;
        end
    end

    // ------------------------------------------------------------
    // Converter: 8-bit code scaled to millivolts
    // ------------------------------------------------------------
    // Scaled from the live code so the result is ready with adc_done
    assign mv_prod = 19'(analog_input_one) *
                     19'(`GPSI_ADC_FULL_MV);

    always_ff @(posedge clk) begin
        if (reset) begin
            adc_mv_ff <= 11'h000;
            adc_done_ff <= 1'b0;
            adc_err_ff <= 1'b0;
        end else begin
            adc_done_ff <= adc_valid;
            if (adc_valid) begin
                if (adc_cmd.ch == `GPSI_ADC_CH &&
                    adc_cmd.fmt == `GPSI_ADC_FMT) begin
                    adc_mv_ff <= 11'(mv_prod /
                        19'(`GPSI_ADC_MAX_CODE));
                    adc_err_ff <= 1'b0;
                end else begin
                    adc_err_ff <= 1'b1;
                end
            end
        end
    end

    assign adc_done = adc_done_ff;
    assign adc_err = adc_err_ff;
    assign adc_mv = adc_mv_ff;
endmodule : gpsi_gpio

// *** test/gpsi_gpio_props.sv ***
module gpsi_gpio_props
import gpsi_pkg::*;
#(
    parameter int NPAD = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rd_valid,
    input wire logic rd_done,
    input wire logic [NPAD*2-1:0] pad_mode,
    input wire logic [NPAD-1:0] out_level,
    input wire logic [NPAD-1:0] pad_out,
    input wire logic [NPAD-1:0] pad_oe,
    input wire logic [NPAD-1:0] pad_pd_en,
    input wire logic [NPAD-1:0] alt_out,
    input wire logic [NPAD-1:0] alt_oe,
    input wire gpsi_net_t net_state,
    input wire logic adc_valid,
    input wire gpsi_adc_cmd_t adc_cmd,
    input wire logic adc_done,
    input wire logic adc_err
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Checks; pad one holds the indicator
    // ----------------------------------------
    // Four samples cover the two-cycle lag of the indicator
    sequence s_off;
        (net_state == GPSI_NET_OFF) [*4];
    endsequence
    sequence s_unreg;
        (net_state == GPSI_NET_UNREG) [*4];
    endsequence
    property p_rd_ans; rd_valid |=> rd_done; endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read answer missing");
    property p_pd; &pad_pd_en; endproperty
    a_pd: assert property (p_pd)
        else $error("pull-down off");
    property p_in_quiet; pad_mode[3:2] == 2'h0 |-> !pad_oe[1]; endproperty
    a_in_quiet: assert property (p_in_quiet)
        else $error("input pad driven");
    property p_out_drive;
        pad_mode[3:2] == 2'h1 |-> pad_oe[1] && pad_out[1] == out_level[1];
    endproperty
    a_out_drive: assert property (p_out_drive)
        else $error("output pad not driving level");
    property p_alt;
        pad_mode[5:4] == 2'h2 |-> {pad_oe[2], pad_out[2]} ==
            {alt_oe[2], alt_out[2]};
    endproperty
    a_alt: assert property (p_alt)
        else $error("alternate pad ignores firmware");
    property p_adc_ok; adc_valid && adc_cmd == 8'h12 |=> adc_done && !adc_err;
    endproperty
    a_adc_ok: assert property (p_adc_ok)
        else $error("legal conversion refused");
    property p_adc_bad; adc_valid && adc_cmd != 8'h12 |=> adc_err; endproperty
    a_adc_bad: assert property (p_adc_bad)
        else $error("illegal conversion accepted");
    property p_ind_off; s_off ##0 pad_mode[1:0] == 2'h2 |-> pad_out[0];
    endproperty
    a_ind_off: assert property (p_ind_off)
        else $error("indicator lit while off");
    property p_ind_unreg; s_unreg ##0 pad_mode[1:0] == 2'h2 |-> !pad_out[0];
    endproperty
    a_ind_unreg: assert property (p_ind_unreg)
        else $error("indicator dark while unregistered");
endmodule : gpsi_gpio_props
bind gpsi_gpio gpsi_gpio_props #(
    .NPAD(NPAD)
) u_props (
    .clk(clk),
    .reset(reset),
    .rd_valid(rd_valid),
    .rd_done(rd_done),
    .pad_mode(pad_mode),
    .out_level(out_level),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pd_en(pad_pd_en),
    .alt_out(alt_out),
    .alt_oe(alt_oe),
    .net_state(net_state),
    .adc_valid(adc_valid),
    .adc_cmd(adc_cmd),
    .adc_done(adc_done),
    .adc_err(adc_err)
);

// *** test/gpsi_ext.sv ***
module gpsi_ext (
    input wire logic [9:0] pad_out,
    input wire logic [9:0] pad_oe,
    input wire logic [9:0] ext_en,
    input wire logic [9:0] ext_lvl,
    output logic [9:0] pad_in,
    output logic led_lit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pad drive wins; a line nobody drives falls to the pull-down
    assign pad_in = (pad_oe & pad_out) |
                    (~pad_oe & ext_en & ext_lvl);
    // The transistor stage inverts the pin
    assign led_lit = ~pad_in[0];
endmodule : gpsi_ext

// *** test/tb.sv ***
module tb
import gpsi_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
typedef struct packed {
    logic [3:0] pad;
    logic [1:0] mode;
    logic lv, en, ex, rd, oe;
} gpsi_row_t;
logic clk, reset, cfg_valid, wr_valid, rd_valid, rd_done, led_lit;
logic [19:0] mv_exp;
logic voice_call, dialup, paging_wake, adc_valid, adc_done, adc_err;
logic [9:0] wr_mask, wr_level, rd_level, out_level, alt_out, alt_oe;
logic [9:0] pad_in, pad_out, pad_oe, pad_pd_en, ext_en, ext_lvl;
logic [19:0] pad_mode;
logic [7:0] analog_input_one;
logic [10:0] adc_mv;
logic [7:0] cv [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
gpsi_pin_cmd_t cfg_cmd;
gpsi_adc_cmd_t adc_cmd;
gpsi_net_t net_state;
gpsi_row_t r;
int mismatches, comparisons, cycles, k;
// Pad, mode, write level, far drive on, far level, read, enable
gpsi_row_t rows [6] = '{
    '{4'h4, 2'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0},
    '{4'h4, 2'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
    '{4'h2, 2'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
    '{4'h2, 2'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1},
    '{4'ha, 2'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
    '{4'h5, 2'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0}};
// Short blink counts keep the run bounded
gpsi_gpio #(
    .ON_MS(1),
    .OFF_MS(2)
) u_gpsi_gpio (
    .clk(clk),
    .reset(reset),
    .cfg_valid(cfg_valid),
    .cfg_cmd(cfg_cmd),
    .wr_valid(wr_valid),
    .wr_mask(wr_mask),
    .wr_level(wr_level),
    .rd_valid(rd_valid),
    .rd_done(rd_done),
    .rd_level(rd_level),
    .out_level(out_level),
    .pad_mode(pad_mode),
    .alt_out(alt_out),
    .alt_oe(alt_oe),
    .net_state(net_state),
    .voice_call(voice_call),
    .dialup(dialup),
    .paging_wake(paging_wake),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_pd_en(pad_pd_en),
    .adc_valid(adc_valid),
    .adc_cmd(adc_cmd),
    .analog_input_one(analog_input_one),
    .adc_done(adc_done),
    .adc_err(adc_err),
    .adc_mv(adc_mv)
);
gpsi_ext u_gpsi_ext (
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .ext_en(ext_en),
    .ext_lvl(ext_lvl),
    .pad_in(pad_in),
    .led_lit(led_lit)
);
initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
end
always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
        mismatches++;
        conclude();
    end
end
task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #1;
endtask : tick
task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
    comparisons++;
    if (got !== exp) begin
        mismatches++;
        $display("mismatch %s exp %0h got %0h", what, exp, got);
    end
endtask : chk
task automatic cfg(logic [3:0] pad, logic [1:0] m);
    cfg_valid = 1'h1;
    cfg_cmd = '{pad, 2'h0, m};
    tick();
    cfg_valid = 1'h0;
    tick();
endtask : cfg
task automatic pulse_wr(logic [9:0] m, logic [9:0] v);
    wr_mask = m;
    wr_level = v;
    wr_valid = 1'h1;
    tick();
    wr_valid = 1'h0;
    rd_valid = 1'h1;
    tick();
    rd_valid = 1'h0;
    chk("rd_done", 20'h0_0001, 20'(rd_done));
    tick();
endtask : pulse_wr
task automatic conv(logic [3:0] f, logic [7:0] v);
    adc_valid = 1'h1;
    adc_cmd = '{4'h1, f};
    analog_input_one = v;
    tick();
    adc_valid = 1'h0;
    chk("adc_done", 20'h0_0001, 20'(adc_done));
    tick();
endtask : conv
task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask : conclude
initial begin
    {reset, cfg_valid, wr_valid, rd_valid, voice_call, dialup} = 6'h3f;
    {cfg_valid, wr_valid, rd_valid, voice_call, dialup} = 5'h00;
    {paging_wake, adc_valid, cfg_cmd, adc_cmd} = 18'h0_0000;
    {wr_mask, wr_level, alt_out, alt_oe, ext_en, ext_lvl} = 60'h0;
    analog_input_one = 8'h00;
    net_state = GPSI_NET_OFF;
    tick(2);
    reset = 1'h0;
    chk("mode", 20'h0_0000, pad_mode);
    chk("oe", 20'h0_0000, 20'(pad_oe));
    chk("pd", 20'h0_03ff, 20'(pad_pd_en));
    chk("rd_level", 20'h0_0000, 20'(rd_level));
    chk("mv", 20'h0_0000, 20'(adc_mv));
    cfg(4'h0, 2'h1);
    cfg(4'hb, 2'h1);
    chk("refused", 20'h0_0000, pad_mode);
    $display("test reset done");
    foreach (rows[i]) begin
        r = rows[i];
        k = int'(r.pad) - 1;
        cfg(r.pad, r.mode);
        ext_en[k] = r.en;
        ext_lvl[k] = r.ex;
        pulse_wr(10'h001 << k, {10{r.lv}});
        chk("rd_level", 20'(r.rd), 20'(rd_level[k]));
        chk("pad_oe", 20'(r.oe), 20'(pad_oe[k]));
        chk("out_level", 20'(r.oe & r.lv), 20'(out_level[k]));
        chk("pad_out", 20'(r.oe & r.lv), 20'(pad_out[k]));
        ext_en[k] = 1'h0;
    end
    $display("test table done");
    cfg(4'h3, 2'h2);
    {alt_out, alt_oe} = {10'h004, 10'h004};
    pulse_wr(10'h004, 10'h000);
    chk("alt", 20'h0_0003, 20'({pad_oe[2], pad_out[2]}));
    $display("test alternate done");
    net_state = GPSI_NET_UNREG;
    cfg(4'h1, 2'h2);
    tick(4);
    chk("led unreg", 20'h0_0001, 20'(led_lit));
    net_state = GPSI_NET_OFF;
    tick(4);
    chk("led off", 20'h0_0000, 20'(led_lit));
    net_state = GPSI_NET_IDLE;
    tick(50);
    chk("led idle", 20'h0_0001, 20'(led_lit));
    dialup = 1'h1;
    tick(50);
    chk("led dialup", 20'h0_0001, 20'(led_lit));
    net_state = GPSI_NET_PSAVE;
    dialup = 1'h0;
    tick(24);
    // Entering power save keeps the lit state until a paging wake
    chk("led hold", 20'h0_0001, 20'(led_lit));
    paging_wake = 1'h1;
    tick();
    paging_wake = 1'h0;
    tick(3);
    chk("led wake", 20'h0_0000, 20'(led_lit));
    voice_call = 1'h1;
    tick(4);
    chk("led call", 20'h0_0001, 20'(led_lit));
    $display("test indicator done");
    foreach (cv[i]) begin
        conv(4'h2, cv[i]);
        mv_exp = 20'(cv[i]) * 20'h0_06a4 / 20'h0_00ff;
        chk("mv", mv_exp, 20'({adc_err, adc_mv}));
    end
    conv(4'h3, 8'h00);
    chk("bad", 20'h0_0ea4, 20'({adc_err, adc_mv}));
    $display("test converter done");
    reset = 1'h1;
    tick(2);
    reset = 1'h0;
    chk("mode", 20'h0_0000, pad_mode);
    chk("out_level", 20'h0_0000, 20'(out_level));
    chk("mv", 20'h0_0000, 20'({adc_err, adc_mv}));
    $display("test second reset done");
    conclude();
end
endmodule : tb
